// ---- dv/slmm_meas_src.sv ----
// sample source model for the measurement link
// assumes meas_clk runs free; samples are offered one at a time
`timescale 1ns/10ps
`default_nettype none

module slmm_meas_src
   import slmm_pkg::*;
(
   // link clock
   input  wire logic        meas_clk,
   // handshake
   input  wire logic        meas_ready,
   output var  slmm_meas_s  meas_sample,
   output var  logic        meas_valid
);
   // idle link at start
   initial
   begin
      meas_valid  = 1'h0;
      meas_sample = '0;
   end

   // wait for an edge at which ready was high, bounded
   task automatic wait_ready();
      logic ok;
      int   n;
      n = 0;
      do
      begin
         #1 ok = meas_ready;
         @(posedge meas_clk);
         n++;
      end
      while (!ok && n < 64);
   endtask

   // offer one word and hold it until taken
   task automatic send(input logic [PW-1:0] p, input logic c, input logic [15:0] v);
      @(posedge meas_clk);
      meas_valid  <= 1'h1;
      meas_sample <= '{page: p, is_current: c, code: v};
      wait_ready();
      meas_valid  <= 1'h0;
      meas_sample <= ~meas_sample; // no stale word once released
      repeat (2) @(posedge meas_clk);
      wait_ready();
   endtask
endmodule // slmm_meas_src

`default_nettype wire

// ---- dv/tb_slmm_top.sv ----
// bench of the supply limit and margin monitor
// assumes slmm_meas_src feeds the link; status is read back as words
`timescale 1ns/10ps
`default_nettype none

module tb_slmm_top
   import slmm_pkg::*;
;
   logic clk, meas_clk, reset, cmd_valid, cmd_write, rsp_valid, rsp_err, meas_valid, meas_ready;
   logic margin_high_go, margin_low_go, margin_apply, fault_req, alert_out, alert_oe_n;
   logic [PW-1:0] cmd_page, margin_page, margin_apply_page, fault_page, p;
   logic [7:0]  cmd_code;
   logic [15:0] cmd_wdata, rsp_data, margin_apply_target, fault_action, d;
   logic [NCH-1:0] supply_enabled, pg_on_reached, margin_fail;
   slmm_meas_s  meas_sample;
   int          err_total, total_checks, i;
   logic [32:0] rq[$];
   logic [19:0] mq[$], fq[$];
   localparam logic [32:0] ER = {1'h1, 16'hFFFF, 16'h0};
   // per-page words and their reset values
   logic [7:0]  cw[9] = '{CMD_MGN_HI, CMD_MGN_LO, CMD_SCALE, CMD_GAIN, CMD_OVF, CMD_OVW, CMD_UVW, CMD_UVF, CMD_OCW};
   logic [15:0] rv[9] = '{RST_ZERO, RST_ZERO, RST_SCALE, RST_ZERO, RST_HIGH, RST_HIGH, RST_ZERO, RST_ZERO, RST_HIGH};

   slmm_top DUT (.clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_page(cmd_page),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err),
      .meas_clk(meas_clk), .meas_valid(meas_valid), .meas_sample(meas_sample), .meas_ready(meas_ready),
      .supply_enabled(supply_enabled), .pg_on_reached(pg_on_reached), .margin_fail(margin_fail),
      .margin_high_go(margin_high_go), .margin_low_go(margin_low_go), .margin_page(margin_page),
      .margin_apply(margin_apply), .margin_apply_page(margin_apply_page),
      .margin_apply_target(margin_apply_target), .fault_req(fault_req), .fault_page(fault_page),
      .fault_action(fault_action), .alert_out(alert_out), .alert_oe_n(alert_oe_n));
   slmm_meas_src PM (.meas_clk(meas_clk), .meas_ready(meas_ready), .meas_valid(meas_valid),
      .meas_sample(meas_sample));

   // clocks with unrelated phase
   initial
   begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   initial
   begin
      meas_clk = 1'h0;
      #13;
      forever #32 meas_clk = ~meas_clk;
   end

   task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one compare per kind of result; the queue note is the expectation
   task automatic cmp_rsp(input logic [32:0] x);
      cmp({3'h0, rsp_err, rsp_data & x[31:16]}, {3'h0, x[32], x[15:0]});
   endtask

   task automatic cmp_mgn(input logic [19:0] x);
      cmp({margin_apply_page, margin_apply_target}, x);
   endtask

   task automatic cmp_flt(input logic [19:0] x);
      cmp({16'h0, fault_page}, x);
   endtask

   task automatic summarize();
      if (err_total == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // one command pulse; the expected answer is noted first
   task automatic cmd(input logic w, input logic [PW-1:0] pg, input logic [7:0] c, input logic [15:0] v,
                      input logic [32:0] x);
      rq.push_back(x);
      @(posedge clk);
      cmd_valid <= 1'h1;
      cmd_write <= w;
      cmd_page  <= pg;
      cmd_code  <= c;
      cmd_wdata <= v;
      @(posedge clk);
      cmd_valid <= 1'h0;
      cmd_wdata <= ~v;
   endtask

   task automatic wr(input logic [PW-1:0] pg, input logic [7:0] c, input logic [15:0] v);
      cmd(1'h1, pg, c, v, {1'h0, 16'hFFFF, 16'h0});
   endtask

   task automatic rd(input logic [PW-1:0] pg, input logic [7:0] c, input logic [15:0] m, input logic [15:0] v);
      cmd(1'h0, pg, c, 16'h0, {1'h0, m, v});
   endtask

   task automatic go(input logic lo, input logic [PW-1:0] pg, input logic [15:0] t);
      mq.push_back({pg, t});
      @(posedge clk);
      margin_page    <= pg;
      margin_high_go <= !lo;
      margin_low_go  <= lo;
      @(posedge clk);
      margin_high_go <= 1'h0;
      margin_low_go  <= 1'h0;
   endtask

   // clear the page, send one sample, read one status bit back
   task automatic ev(input logic [PW-1:0] pg, input logic c, input logic [15:0] v, input logic [7:0] s,
                     input int b, input logic x, input logic f);
      wr(pg, CMD_CLEAR, 16'h0);
      if (f)
         fq.push_back({16'h0, pg});
      PM.send(pg, c, v);
      repeat (4) @(posedge clk);
      rd(pg, s, 16'h1 << b, 16'(x) << b);
   endtask

   // watcher: outputs are settled by the falling edge
   always @(negedge clk)
   begin
      if (rsp_valid === 1'h1)
         cmp_rsp(rq.size() ? rq.pop_front() : 'x);
      if (margin_apply === 1'h1)
         cmp_mgn(mq.size() ? mq.pop_front() : 'x);
      if (fault_req === 1'h1)
         cmp_flt(fq.size() ? fq.pop_front() : 'x);
   end

   // hang guard, well past the expected run
   initial
   begin
      #500000;
      err_total++;
      summarize();
   end

   initial
   begin
      {cmd_valid, cmd_write, margin_high_go, margin_low_go, cmd_page, margin_page} = '0;
      {cmd_code, cmd_wdata, margin_fail, pg_on_reached} = '0;
      supply_enabled = '1;
      reset = 1'h1;
      err_total = 0;
      total_checks = 0;
      void'($urandom(32'hB66B9129));
      // the link side resets through its own flops; the first sample comes much later
      repeat (12) @(posedge clk);
      reset <= 1'h0;
      for (i = 0; i < 9; i++)
         rd(4'(i), cw[i], 16'hFFFF, rv[i]);
      for (i = 0; i < 9; i++)
      begin
         d = 16'($urandom);
         p = 4'($urandom);
         wr(p, cw[i], d);
         rd(p, cw[i], 16'hFFFF, d);
         wr(p, cw[i], rv[i]);
      end
      cmd(1'h0, 4'h0, 8'h11, 16'h0, ER);
      cmd(1'h1, 4'h0, CMD_STS_WRD, 16'hFFFF, ER);
      cmd(1'h0, 4'h0, CMD_CLEAR, 16'h0, ER);
      // a rewrite while margined must wait for the next go
      for (i = 0; i < 2; i++)
      begin
         p = 4'(5 + i);
         d = 16'($urandom);
         wr(p, cw[i], d);
         go(i[0], p, d);
         wr(p, cw[i], ~d);
         repeat (3) @(posedge clk);
         cmp({margin_apply_page, margin_apply_target}, {p, d});
         go(i[0], p, ~d);
      end
      wr(4'h0, CMD_FACT, 16'h00A5);
      wr(4'h1, CMD_OVF, 16'h03E8);
      ev(4'h1, 1'h0, 16'h03E9, CMD_STS_VO, 7, 1'h1, 1'h1);
      rd(4'h1, CMD_STS_WRD, 16'h8020, 16'h8020);
      cmp({4'h0, fault_action}, 20'h000A5);
      ev(4'h1, 1'h0, 16'h03DE, CMD_STS_VO, 7, 1'h1, 1'h0);
      ev(4'h1, 1'h0, 16'h03D3, CMD_STS_VO, 7, 1'h0, 1'h0);
      wr(4'h4, CMD_SCALE, 16'h4000);
      wr(4'h4, CMD_OVW, 16'h03E8);
      ev(4'h4, 1'h0, 16'h01F4, CMD_STS_VO, 6, 1'h0, 1'h0);
      ev(4'h4, 1'h0, 16'h01F5, CMD_STS_VO, 6, 1'h1, 1'h0);
      ev(4'h4, 1'h0, 16'h01EB, CMD_STS_VO, 6, 1'h1, 1'h0);
      ev(4'h4, 1'h0, 16'h01E9, CMD_STS_VO, 6, 1'h0, 1'h0);
      wr(4'h2, CMD_UVW, 16'h03E8);
      wr(4'h7, CMD_UVF, 16'h03E8);
      ev(4'h2, 1'h0, 16'h03E7, CMD_STS_VO, 5, 1'h0, 1'h0);
      ev(4'h7, 1'h0, 16'h03E7, CMD_STS_VO, 4, 1'h0, 1'h0);
      @(posedge clk);
      pg_on_reached <= 16'h0084;
      ev(4'h2, 1'h0, 16'h03E7, CMD_STS_VO, 5, 1'h1, 1'h0);
      ev(4'h2, 1'h0, 16'h03FC, CMD_STS_VO, 5, 1'h1, 1'h0);
      ev(4'h2, 1'h0, 16'h03FD, CMD_STS_VO, 5, 1'h0, 1'h0);
      ev(4'h7, 1'h0, 16'h03E7, CMD_STS_VO, 4, 1'h1, 1'h1);
      ev(4'h7, 1'h0, 16'h03FC, CMD_STS_VO, 4, 1'h1, 1'h0);
      ev(4'h7, 1'h0, 16'h03FD, CMD_STS_VO, 4, 1'h0, 1'h0);
      @(posedge clk);
      supply_enabled <= 16'hFF7B;
      ev(4'h7, 1'h0, 16'h03E7, CMD_STS_VO, 4, 1'h0, 1'h0);
      ev(4'h2, 1'h0, 16'h03E7, CMD_STS_VO, 5, 1'h0, 1'h0);
      wr(4'h8, CMD_GAIN, 16'h0002);
      wr(4'h8, CMD_OCW, 16'h01F4);
      ev(4'h8, 1'h1, 16'h03E9, CMD_STS_IO, 5, 1'h1, 1'h0);
      rd(4'h8, CMD_STS_WRD, 16'h4000, 16'h4000);
      ev(4'h8, 1'h1, 16'h03B7, CMD_STS_IO, 5, 1'h1, 1'h0);
      ev(4'h8, 1'h1, 16'h03B5, CMD_STS_IO, 5, 1'h0, 1'h0);
      // no flag stands on any page now, so the alert line must be released
      @(negedge clk);
      cmp({19'h0, alert_oe_n}, 20'h1);
      rd(4'h0, CMD_MODE, 16'hFFFF, RST_MODE);
      @(posedge clk);
      margin_fail <= 16'h0008;
      @(posedge clk);
      margin_fail <= '0;
      repeat (2) @(posedge clk);
      cmp({18'h0, alert_out, alert_oe_n}, 20'h0);
      rd(4'h3, CMD_STS_MFR, 16'h0001, 16'h0001);
      rd(4'h3, CMD_STS_WRD, 16'h0100, 16'h0100);
      // alerts disabled: the margin flag stays but the line lets go
      wr(4'h0, CMD_MODE, 16'h0000);
      @(posedge clk);
      @(negedge clk);
      cmp({18'h0, alert_out, alert_oe_n}, 20'h1);
      rd(4'h3, CMD_STS_MFR, 16'h0001, 16'h0001);
      repeat (4) @(posedge clk);
      cmp(20'(rq.size() + mq.size() + fq.size()), 20'h0);
      cmp({19'h0, meas_ready}, 20'h1);
      summarize();
   end
endmodule // tb_slmm_top

`default_nettype wire

// ---- pkg/slmm_pkg.sv ----
// constants, command codes and carrier types of the supply limit and margin monitor
// assumes a 16-page command space reached by a byte-wide command code
package slmm_pkg;

   // channel count and page width
   localparam int NCH = 16;
   localparam int PW  = 4;

   // command codes of the per-page words
   localparam logic [7:0] CMD_MGN_HI  = 8'h25;
   localparam logic [7:0] CMD_MGN_LO  = 8'h26;
   localparam logic [7:0] CMD_SCALE   = 8'h2A;
   localparam logic [7:0] CMD_GAIN    = 8'h38;
   localparam logic [7:0] CMD_OVF     = 8'h40;
   localparam logic [7:0] CMD_OVW     = 8'h42;
   localparam logic [7:0] CMD_UVW     = 8'h43;
   localparam logic [7:0] CMD_UVF     = 8'h44;
   localparam logic [7:0] CMD_OCW     = 8'h46;
   // status, clear and configuration codes
   localparam logic [7:0] CMD_CLEAR   = 8'h03;
   localparam logic [7:0] CMD_STS_WRD = 8'h79;
   localparam logic [7:0] CMD_STS_VO  = 8'h7A;
   localparam logic [7:0] CMD_STS_IO  = 8'h7B;
   localparam logic [7:0] CMD_STS_MFR = 8'h80;
   localparam logic [7:0] CMD_MODE    = 8'hD1;
   localparam logic [7:0] CMD_FACT    = 8'hD5;

   // reset values
   localparam logic [15:0] RST_ZERO  = 16'h0000;
   localparam logic [15:0] RST_HIGH  = 16'hFFFF;
   localparam logic [15:0] RST_SCALE = 16'h7FFF;
   localparam logic [15:0] RST_MODE  = 16'h0001;

   // scale code 7FFF is a ratio of one; adc full scale 2048 mV
   localparam logic [47:0] SCALE_UNITY = 48'h7FFF;
   localparam logic [15:0] ADC_FS_MV   = 16'h0800;
   // adc code weight against limit times gain (0.1 milliohm units)
   localparam logic [47:0] I_UNIT      = 48'h1;
   // hysteresis ratios: 2 % is 49/50 and 51/50, 5 % is 19/20
   localparam logic [47:0] HV_BASE = 48'h32;
   localparam logic [47:0] HV_LO   = 48'h31;
   localparam logic [47:0] HV_HI   = 48'h33;
   localparam logic [47:0] HI_BASE = 48'h14;
   localparam logic [47:0] HI_LO   = 48'h13;

   // status bit positions
   localparam int SW_VOUT   = 15;
   localparam int SW_IOUT   = 14;
   localparam int SW_MARGIN = 8;
   localparam int SW_OV     = 5;
   localparam int SV_OVF    = 7;
   localparam int SV_OVW    = 6;
   localparam int SV_UVW    = 5;
   localparam int SV_UVF    = 4;
   localparam int SI_OCW    = 5;
   localparam int SM_MGF    = 0;
   localparam int MODE_ALRT = 0;

   // one measurement crossing from the link side
   typedef struct packed {
      logic [PW-1:0] page;
      logic          is_current;
      logic [15:0]   code;
   } slmm_meas_s;

   // per-channel condition and sticky flags
   typedef struct packed {
      logic ov_f;
      logic ov_w;
      logic uv_w;
      logic uv_f;
      logic oc_w;
      logic mg_f;
   } slmm_flags_s;

endpackage

// ---- src/slmm_top.sv ----
// supply limit and margin monitor: per-page limits, hysteresis, sticky status, alert
// assumes measurements arrive on meas_clk and commands come from a decoder on clk
`timescale 1ns/10ps
`default_nettype none

module slmm_top
   import slmm_pkg::*;
(
   // system
   input  wire logic             clk,
   input  wire logic             reset,
   // command port
   input  wire logic             cmd_valid,
   input  wire logic             cmd_write,
   input  wire logic [PW-1:0]    cmd_page,
   input  wire logic [7:0]       cmd_code,
   input  wire logic [15:0]      cmd_wdata,
   output logic                  rsp_valid,
   output logic [15:0]           rsp_data,
   output logic                  rsp_err,
   // measurement link
   input  wire logic             meas_clk,
   input  wire logic             meas_valid,
   input  wire slmm_meas_s       meas_sample,
   output logic                  meas_ready,
   // sequencer and margining loop
   input  wire logic [NCH-1:0]   supply_enabled,
   input  wire logic [NCH-1:0]   pg_on_reached,
   input  wire logic [NCH-1:0]   margin_fail,
   input  wire logic             margin_high_go,
   input  wire logic             margin_low_go,
   input  wire logic [PW-1:0]    margin_page,
   output logic                  margin_apply,
   output logic [PW-1:0]         margin_apply_page,
   output logic [15:0]           margin_apply_target,
   // fault response and alert
   output logic                  fault_req,
   output logic [PW-1:0]         fault_page,
   output logic [15:0]           fault_action,
   output logic                  alert_out,
   output logic                  alert_oe_n
);

   // per-page words
   logic [15:0]      up_q   [NCH];
   logic [15:0]      dn_q   [NCH];
   logic [15:0]      scl_q  [NCH];
   logic [15:0]      gain_q [NCH];
   logic [15:0]      ovf_q  [NCH];
   logic [15:0]      ovw_q  [NCH];
   logic [15:0]      uvw_q  [NCH];
   logic [15:0]      uvf_q  [NCH];
   logic [15:0]      ocw_q  [NCH];
   slmm_flags_s      cond_q [NCH];
   slmm_flags_s      flg_q  [NCH];
   logic [NCH-1:0]   arm_q;
   logic [NCH-1:0]   flg_any;
   logic [15:0]      mode_q;
   logic [15:0]      act_q;
   // link side
   logic             lrst_s1;
   logic             lrst_q;
   logic             ack_s1;
   logic             ack_s2;
   logic             req_tgl_q;
   logic             lready_q;
   slmm_meas_s       hold_q;
   // system side of the crossing
   logic             req_s1;
   logic             req_s2;
   logic             ack_tgl_q;
   logic             s1_q;
   slmm_meas_s       smp_q;
   // evaluation
   logic [PW-1:0]    pg;
   logic [47:0]      vv;
   logic [47:0]      ii;
   logic [47:0]      t_ovf;
   logic [47:0]      t_ovw;
   logic [47:0]      t_uvw;
   logic [47:0]      t_uvf;
   logic [47:0]      t_ocw;
   slmm_flags_s      cur;
   slmm_flags_s      nc;
   // command decode
   logic             wr_en;
   logic             rd_hit;
   logic             rd_only;
   logic             wr_only;
   logic [15:0]      rd_data;
   slmm_flags_s      fsel;
   logic [15:0]      sw;
   logic [15:0]      hi_sel;
   logic [15:0]      lo_sel;
   // output registers
   logic             rsp_valid_q;
   logic [15:0]      rsp_data_q;
   logic             rsp_err_q;
   logic             mg_apply_q;
   logic [PW-1:0]    mg_page_q;
   logic [15:0]      mg_tgt_q;
   logic             fault_req_q;
   logic [PW-1:0]    fault_page_q;
   logic [15:0]      fault_act_q;
   logic             alert_oe_n_q;
   logic             alert_out_q;

   assign rsp_valid           = rsp_valid_q;
   assign rsp_data            = rsp_data_q;
   assign rsp_err             = rsp_err_q;
   assign meas_ready          = lready_q;
   assign margin_apply        = mg_apply_q;
   assign margin_apply_page   = mg_page_q;
   assign margin_apply_target = mg_tgt_q;
   assign fault_req           = fault_req_q;
   assign fault_page          = fault_page_q;
   assign fault_action        = fault_act_q;
   assign alert_out           = alert_out_q;
   assign alert_oe_n          = alert_oe_n_q;

   // reset and acknowledge brought into the link domain
   always_ff @(posedge meas_clk)
   begin
      lrst_s1 <= reset;
      lrst_q  <= lrst_s1;
      ack_s1  <= ack_tgl_q;
      ack_s2  <= ack_s1;
   end

   // link holds one sample until acknowledged; no queue, so ready drops meanwhile
   always_ff @(posedge meas_clk)
   begin
      if (lrst_q)
      begin
         req_tgl_q <= 1'b0;
         lready_q  <= 1'b0;
         hold_q    <= '0;
      end
      else if (lready_q && meas_valid)
      begin
         hold_q    <= meas_sample;
         req_tgl_q <= ~req_tgl_q;
         lready_q  <= 1'b0;
      end
      else if (!lready_q && ack_s2 == req_tgl_q)
      begin
         lready_q  <= 1'b1;
      end
   end

   // request toggle synchroniser
   always_ff @(posedge clk)
   begin
      req_s1 <= req_tgl_q;
      req_s2 <= req_s1;
   end

   // hold_q is stable while the toggle is in flight, so it is sampled directly
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ack_tgl_q <= 1'b0;
         s1_q      <= 1'b0;
         smp_q     <= '0;
      end
      else
      begin
         s1_q <= req_s2 ^ ack_tgl_q;
         if (req_s2 ^ ack_tgl_q)
         begin
            smp_q     <= hold_q;
            ack_tgl_q <= req_s2;
         end
      end
   end

   // supply-referred comparison without a divider: adc*32767 against limit*scale
   assign pg    = smp_q.page;
   assign vv    = 48'(smp_q.code) * SCALE_UNITY;
   assign ii    = 48'(smp_q.code) * I_UNIT;
   assign t_ovf = 48'(ovf_q[pg]) * 48'(scl_q[pg]);
   assign t_ovw = 48'(ovw_q[pg]) * 48'(scl_q[pg]);
   assign t_uvw = 48'(uvw_q[pg]) * 48'(scl_q[pg]);
   assign t_uvf = 48'(uvf_q[pg]) * 48'(scl_q[pg]);
   assign t_ocw = 48'(ocw_q[pg]) * 48'(gain_q[pg]);

   // next condition of the measured page, each limit held until past its band
   always_comb
   begin
      cur = cond_q[pg];
      nc  = cur;
      if (smp_q.is_current)
      begin
         nc.oc_w = cur.oc_w ? (ii * HI_BASE >= t_ocw * HI_LO) : (ii > t_ocw);
      end
      else
      begin
         nc.ov_f = cur.ov_f ? (vv * HV_BASE >= t_ovf * HV_LO) : (vv > t_ovf);
         nc.ov_w = cur.ov_w ? (vv * HV_BASE >= t_ovw * HV_LO) : (vv > t_ovw);
         nc.uv_w = arm_q[pg] &&
                   (cur.uv_w ? (vv * HV_BASE <= t_uvw * HV_HI) : (vv < t_uvw));
         nc.uv_f = arm_q[pg] &&
                   (cur.uv_f ? (vv * HV_BASE <= t_uvf * HV_HI) : (vv < t_uvf));
      end
   end

   assign wr_en = cmd_valid && cmd_write;

   // per-channel words, masking and flags
   for (genvar i = 0; i < NCH; i++)
   begin : g_ch
      // word writes; every word is a full sixteen-bit value
      always_ff @(posedge clk)
      begin
         if (reset)
         begin
            up_q[i]   <= RST_ZERO;
            dn_q[i]   <= RST_ZERO;
            scl_q[i]  <= RST_SCALE;
            gain_q[i] <= RST_ZERO;
            ovf_q[i]  <= RST_HIGH;
            ovw_q[i]  <= RST_HIGH;
            uvw_q[i]  <= RST_ZERO;
            uvf_q[i]  <= RST_ZERO;
            ocw_q[i]  <= RST_HIGH;
         end
         else if (wr_en && cmd_page == PW'(i))
         begin
            case (cmd_code)
               CMD_MGN_HI: up_q[i]   <= cmd_wdata;
               CMD_MGN_LO: dn_q[i]   <= cmd_wdata;
               CMD_SCALE:  scl_q[i]  <= cmd_wdata;
               CMD_GAIN:   gain_q[i] <= cmd_wdata;
               CMD_OVF:    ovf_q[i]  <= cmd_wdata;
               CMD_OVW:    ovw_q[i]  <= cmd_wdata;
               CMD_UVW:    uvw_q[i]  <= cmd_wdata;
               CMD_UVF:    uvf_q[i]  <= cmd_wdata;
               CMD_OCW:    ocw_q[i]  <= cmd_wdata;
               default:    ;
            endcase
         end
      end

      // undervoltage checks armed at first power good, disarmed when disabled
      always_ff @(posedge clk)
      begin
         if (reset || !supply_enabled[i])
            arm_q[i] <= 1'b0;
         else if (pg_on_reached[i])
            arm_q[i] <= 1'b1;
      end

      // conditions follow the page's own samples; sticky flags, set beats clear
      always_ff @(posedge clk)
      begin
         if (reset)
         begin
            cond_q[i] <= '0;
            flg_q[i]  <= '0;
         end
         else
         begin
            if (s1_q && pg == PW'(i))
               cond_q[i] <= nc;
            flg_q[i] <= ((wr_en && cmd_code == CMD_CLEAR && cmd_page == PW'(i)) ? '0 : flg_q[i])
                      | ((s1_q && pg == PW'(i)) ? nc : '0)
                      | {5'h00, margin_fail[i]};
         end
      end

      assign flg_any[i] = |flg_q[i];

      // every page, not only the first, must keep its overvoltage warning flag and report its margin failures
      a_margin_flag: assert property (@(posedge clk) disable iff (reset)
         margin_fail[i] |=> flg_q[i].mg_f ##1 (!mode_q[MODE_ALRT] || !alert_oe_n_q))
         else $error("margin failure not flagged");
      a_status_sticky: assert property (@(posedge clk) disable iff (reset)
         (flg_q[i].ov_w && !(wr_en && cmd_code == CMD_CLEAR && cmd_page == PW'(i))) |=> flg_q[i].ov_w)
         else $error("flag lost without clear");
   end

   // global mode and fault action words
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         mode_q <= RST_MODE;
         act_q  <= RST_ZERO;
      end
      else if (wr_en && cmd_code == CMD_MODE)
         mode_q <= cmd_wdata;
      else if (wr_en && cmd_code == CMD_FACT)
         act_q  <= cmd_wdata;
   end

   // status word of the addressed page
   always_comb
   begin
      fsel           = flg_q[cmd_page];
      sw             = RST_ZERO;
      sw[SW_VOUT]    = fsel.ov_f | fsel.ov_w | fsel.uv_w | fsel.uv_f;
      sw[SW_IOUT]    = fsel.oc_w;
      sw[SW_MARGIN]  = fsel.mg_f;
      sw[SW_OV]      = fsel.ov_f;
   end

   // read decode; status is read-only, clear is write-only
   always_comb
   begin
      rd_hit  = 1'b1;
      rd_only = 1'b0;
      wr_only = 1'b0;
      rd_data = RST_ZERO;
      case (cmd_code)
         CMD_MGN_HI:  rd_data = up_q[cmd_page];
         CMD_MGN_LO:  rd_data = dn_q[cmd_page];
         CMD_SCALE:   rd_data = scl_q[cmd_page];
         CMD_GAIN:    rd_data = gain_q[cmd_page];
         CMD_OVF:     rd_data = ovf_q[cmd_page];
         CMD_OVW:     rd_data = ovw_q[cmd_page];
         CMD_UVW:     rd_data = uvw_q[cmd_page];
         CMD_UVF:     rd_data = uvf_q[cmd_page];
         CMD_OCW:     rd_data = ocw_q[cmd_page];
         CMD_MODE:    rd_data = mode_q;
         CMD_FACT:    rd_data = act_q;
         CMD_CLEAR:   wr_only = 1'b1;
         CMD_STS_WRD:
         begin
            rd_data = sw;
            rd_only = 1'b1;
         end
         CMD_STS_VO:
         begin
            rd_data[SV_OVF] = fsel.ov_f;
            rd_data[SV_OVW] = fsel.ov_w;
            rd_data[SV_UVW] = fsel.uv_w;
            rd_data[SV_UVF] = fsel.uv_f;
            rd_only = 1'b1;
         end
         CMD_STS_IO:
         begin
            rd_data[SI_OCW] = fsel.oc_w;
            rd_only = 1'b1;
         end
         CMD_STS_MFR:
         begin
            rd_data[SM_MGF] = fsel.mg_f;
            rd_only = 1'b1;
         end
         default:     rd_hit = 1'b0;
      endcase
   end

   // one answer per command, the cycle after it
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         rsp_valid_q <= 1'b0;
         rsp_data_q  <= RST_ZERO;
         rsp_err_q   <= 1'b0;
      end
      else
      begin
         rsp_valid_q <= cmd_valid;
         rsp_data_q  <= (cmd_valid && !cmd_write && !wr_only) ? rd_data : RST_ZERO;
         rsp_err_q   <= cmd_valid && (!rd_hit || (cmd_write ? rd_only : wr_only));
      end
   end

   assign hi_sel = up_q[margin_page];
   assign lo_sel = dn_q[margin_page];

   // target copied only at a margin command, later writes wait for the next one
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         mg_apply_q <= 1'b0;
         mg_page_q  <= '0;
         mg_tgt_q   <= RST_ZERO;
      end
      else
      begin
         mg_apply_q <= margin_high_go || margin_low_go;
         if (margin_high_go)
         begin
            mg_page_q <= margin_page;
            mg_tgt_q  <= hi_sel;
         end
         else if (margin_low_go)
         begin
            mg_page_q <= margin_page;
            mg_tgt_q  <= lo_sel;
         end
      end
   end

   // fault action requested once per new fault entry
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         fault_req_q  <= 1'b0;
         fault_page_q <= '0;
         fault_act_q  <= RST_ZERO;
      end
      else
      begin
         fault_req_q  <= s1_q && ((nc.ov_f && !cur.ov_f) || (nc.uv_f && !cur.uv_f));
         fault_page_q <= pg;
         fault_act_q  <= act_q;
      end
   end

   // open-drain alert pulled low while any flag stands and alerts are enabled
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         alert_oe_n_q <= 1'b1;
         alert_out_q  <= 1'b0;
      end
      else
         alert_oe_n_q <= !(mode_q[MODE_ALRT] && |flg_any);
   end

   // checks on margin copy, fault entry, masking and the answer strobe
   a_margin_high: assert property (@(posedge clk) disable iff (reset)
      margin_high_go |=> mg_apply_q && mg_tgt_q == $past(hi_sel))
      else $error("margin high target not taken at command");
   a_margin_low: assert property (@(posedge clk) disable iff (reset)
      (margin_low_go && !margin_high_go) |=> mg_tgt_q == $past(lo_sel))
      else $error("margin low target not taken at command");
   a_margin_still: assert property (@(posedge clk) disable iff (reset)
      !mg_apply_q |-> $stable(mg_tgt_q))
      else $error("margin target moved without command");
   a_ov_fault_req: assert property (@(posedge clk) disable iff (reset)
      (s1_q && !smp_q.is_current && !cur.ov_f && vv > t_ovf) |=> fault_req_q)
      else $error("overvoltage fault did not request action");
   a_ov_hyst_hold: assert property (@(posedge clk) disable iff (reset)
      (s1_q && !smp_q.is_current && cur.ov_f && vv * HV_BASE >= t_ovf * HV_LO) |-> nc.ov_f)
      else $error("overvoltage fault released inside band");
   a_uv_masked: assert property (@(posedge clk) disable iff (reset)
      (s1_q && !arm_q[pg]) |-> !nc.uv_w && !nc.uv_f)
      else $error("undervoltage check not masked");
   a_rsp_timing: assert property (@(posedge clk) disable iff (reset)
      cmd_valid |=> rsp_valid_q ##1 (!rsp_valid_q || $past(cmd_valid)))
      else $error("answer not one cycle after command");

endmodule // slmm_top

`default_nettype wire
